// *** verilog/cmcc_regs.vh ***
// Register map, field positions, reset values and counts of the master clock control block
`ifndef CMCC_REGS_VH
`define CMCC_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CMCC_ADDR_PORT_ROLE      8'h05
`define CMCC_ADDR_CLOCK_SOURCE   8'h06
`define CMCC_ADDR_RATIO          8'h07
`define CMCC_ADDR_CLOCK_STATE    8'h08

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CMCC_POS_CAP_ROLE        0
`define CMCC_POS_PLAY_ROLE       1
`define CMCC_POS_FORCED_LOCK     0
`define CMCC_POS_SRC_SEL_LO      1
`define CMCC_POS_SRC_SEL_HI      2
`define CMCC_POS_FRAME_LOCK_EN   3
`define CMCC_POS_RANGE_LO        4
`define CMCC_POS_RANGE_HI        5
`define CMCC_POS_SCALE_LO        6
`define CMCC_POS_SCALE_HI        7
`define CMCC_POS_ACTIVE_OSC      3

// ----------------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------------
`define CMCC_RST_PORT_ROLE       2'h0
`define CMCC_RST_CLOCK_SOURCE    8'h00
`define CMCC_SRC_PLL             2'h0
`define CMCC_SRC_OSC             2'h1
`define CMCC_SRC_HOLD            2'h2
`define CMCC_SRC_AUTO            2'h3
`define CMCC_SCALE_DIV1          2'h0
`define CMCC_SCALE_DIV2          2'h1
`define CMCC_SCALE_DIV4          2'h2
`define CMCC_SCALE_MUL2          2'h3
`define CMCC_RANGE_12M           2'h0
`define CMCC_RANGE_18M           2'h1
`define CMCC_RANGE_24M           2'h2
`define CMCC_CODE_FORCED         3'h7

// ----------------------------------------------------------------------------
// Measurement windows and code thresholds (PLL edges per 256 oscillator edges)
// ----------------------------------------------------------------------------
`define CMCC_RATIO_WINDOW        64
`define CMCC_FREQ_WINDOW         256
`define CMCC_THR_0               12'h0CB
`define CMCC_THR_1               12'h0F6
`define CMCC_THR_2               12'h12B
`define CMCC_THR_3               12'h196
`define CMCC_THR_4               12'h1EB
`define CMCC_THR_5               12'h2D6
`define CMCC_THR_6               12'h3D6

// ----------------------------------------------------------------------------
// Serial port divider taps on the master clock edge counter
// ----------------------------------------------------------------------------
`define CMCC_BIT_TAP             1
`define CMCC_FRAME_TAP           7

`endif

// *** verilog/cmcc_edge_window.v ***
// Counts edges of one clock while another clock makes a fixed number of edges
`timescale 1ns/1ns
`default_nettype none
module cmcc_edge_window #(
    parameter REF_COUNT = 64,
    parameter REF_WIDTH = 6,
    parameter WIDTH     = 8
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             refEdge,
    input  wire             measEdge,
    output reg  [WIDTH-1:0] count
);
    localparam [31:0]          REF_FULL = REF_COUNT - 1;
    localparam [REF_WIDTH-1:0] REF_LAST = REF_FULL[REF_WIDTH-1:0];
    localparam [WIDTH-1:0]     MEAS_MAX = {WIDTH{1'b1}};
    localparam [WIDTH-1:0]     MEAS_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

    reg [REF_WIDTH-1:0] refCnt;
    reg [WIDTH-1:0]     measCnt;
    wire [WIDTH-1:0]    next_measCnt;

    // Saturate so an absent reference clock cannot wrap the result
    assign next_measCnt = (measEdge && measCnt != MEAS_MAX) ? measCnt + MEAS_ONE : measCnt;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refCnt  <= {REF_WIDTH{1'b0}};
            measCnt <= {WIDTH{1'b0}};
            count   <= {WIDTH{1'b0}};
        end else if (refEdge && refCnt == REF_LAST) begin
            refCnt  <= {REF_WIDTH{1'b0}};
            count   <= next_measCnt;
            measCnt <= {WIDTH{1'b0}};
        end else begin
            if (refEdge) begin
                refCnt <= refCnt + {{(REF_WIDTH-1){1'b0}}, 1'b1};
            end
            measCnt <= next_measCnt;
        end
    end
endmodule // cmcc_edge_window
`default_nettype wire

// *** verilog/cmcc_clock_control.v ***
// Master clock source selection, recovered clock scaling and serial port clock roles
`timescale 1ns/1ns
`default_nettype none
`include "cmcc_regs.vh"
module cmcc_clock_control (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [7:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrEn,
    input  wire       regRdEn,
    output reg  [7:0] regRdData,
    input  wire       oscClkIn,
    input  wire       pllClkIn,
    input  wire       pllUnlockIn,
    input  wire       playBitClkIn,
    output wire       playBitClkOut,
    output wire       playBitClkOe,
    input  wire       playFrameClkIn,
    output wire       playFrameClkOut,
    output wire       playFrameClkOe,
    input  wire       capBitClkIn,
    output wire       capBitClkOut,
    output wire       capBitClkOe,
    input  wire       capFrameClkIn,
    output wire       capFrameClkOut,
    output wire       capFrameClkOe,
    output reg        masterClkOut,
    output reg        recoveredClockOut,
    output reg        pllRefClkOut,
    output reg        pllFrameLockActive,
    output reg        pllForcedLock,
    output reg  [1:0] pllRangeSel,
    output reg        timingValid,
    output reg        sampleRateDetectEn
);
    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // Index: 0 osc, 1 pll, 2 unlock, 3 capture frame, 4 capture bit,
    // 5 playback frame, 6 playback bit
    localparam NSYNC = 7;
    wire [NSYNC-1:0] rawIn;
    reg  [NSYNC-1:0] syncA;
    reg  [NSYNC-1:0] syncB;
    reg  [NSYNC-1:0] syncC;
    reg  [NSYNC-1:0] lvl;
    reg  [NSYNC-1:0] lvlDly;

    assign rawIn = {playBitClkIn, playFrameClkIn, capBitClkIn, capFrameClkIn,
                    pllUnlockIn, pllClkIn, oscClkIn};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : gSync
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    syncA[gi]  <= 1'b0;
                    syncB[gi]  <= 1'b0;
                    syncC[gi]  <= 1'b0;
                    lvl[gi]    <= 1'b0;
                    lvlDly[gi] <= 1'b0;
                end else begin
                    syncA[gi]  <= rawIn[gi];
                    syncB[gi]  <= syncA[gi];
                    syncC[gi]  <= syncB[gi];
                    // A change counts only once two stages agree
                    if (syncB[gi] == syncC[gi]) begin
                        lvl[gi] <= syncC[gi];
                    end
                    lvlDly[gi] <= lvl[gi];
                end
            end
        end
    endgenerate

    wire oscLvl   = lvl[0];
    wire pllLvl   = lvl[1];
    wire unlock   = lvl[2];
    wire capFrame = lvl[3];
    wire oscRise  = lvl[0] & ~lvlDly[0];
    wire pllRise  = lvl[1] & ~lvlDly[1];

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg [1:0] portRole;
    reg [7:0] clockSource;

    wire       forcedLock   = clockSource[`CMCC_POS_FORCED_LOCK];
    wire [1:0] sourceSel    = clockSource[`CMCC_POS_SRC_SEL_HI:`CMCC_POS_SRC_SEL_LO];
    wire       frameLockEn  = clockSource[`CMCC_POS_FRAME_LOCK_EN];
    wire [1:0] refRange     = clockSource[`CMCC_POS_RANGE_HI:`CMCC_POS_RANGE_LO];
    wire [1:0] recScale     = clockSource[`CMCC_POS_SCALE_HI:`CMCC_POS_SCALE_LO];
    wire       capIsMaster  = portRole[`CMCC_POS_CAP_ROLE];
    wire       playIsMaster = portRole[`CMCC_POS_PLAY_ROLE];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portRole    <= `CMCC_RST_PORT_ROLE;
            clockSource <= `CMCC_RST_CLOCK_SOURCE;
        end else if (regWrEn) begin
            if (regAddr == `CMCC_ADDR_PORT_ROLE) begin
                portRole <= regWrData[1:0];
            end
            if (regAddr == `CMCC_ADDR_CLOCK_SOURCE) begin
                clockSource <= regWrData;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Source decision
    // ------------------------------------------------------------------------
    reg activeOsc;
    reg switching;
    reg wantOsc;
    always @* begin
        case (sourceSel)
            `CMCC_SRC_PLL:  wantOsc = 1'b0;
            `CMCC_SRC_OSC:  wantOsc = 1'b1;
            `CMCC_SRC_HOLD: wantOsc = unlock ? 1'b1 : activeOsc;
            `CMCC_SRC_AUTO: wantOsc = unlock;
            default:        wantOsc = 1'b0;
        endcase
        // Forced lock runs on the PLL with no oscillator present
        if (forcedLock) begin
            wantOsc = 1'b0;
        end
    end
    wire curLvl  = activeOsc ? oscLvl : pllLvl;
    wire newLvl  = activeOsc ? pllLvl : oscLvl;
    wire newFall = !newLvl && (activeOsc ? lvlDly[1] : lvlDly[0]);
    // ------------------------------------------------------------------------
    // Glitch-free master clock switch
    // ------------------------------------------------------------------------
    // Park low on the old source, then join the new one on its falling edge,
    // so neither phase is ever shortened. Costs up to two source periods.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            activeOsc    <= 1'b0;
            switching    <= 1'b0;
            masterClkOut <= 1'b0;
        end else begin
            if (!switching && wantOsc != activeOsc && !curLvl) begin
                switching    <= 1'b1;
                masterClkOut <= 1'b0;
            end else if (switching) begin
                masterClkOut <= 1'b0;
                if (newFall) begin
                    activeOsc <= ~activeOsc;
                    switching <= 1'b0;
                end
            end else begin
                masterClkOut <= curLvl;
            end
        end
    end
    // ------------------------------------------------------------------------
    // Recovered clock
    // ------------------------------------------------------------------------
    // Manual PLL while unlocked shows the oscillator, unless lock is forced
    wire recFromOsc = (sourceSel == `CMCC_SRC_PLL) && unlock && !forcedLock;
    reg  recBase;
    reg  recBaseDly;
    reg  recDiv2;
    reg  [1:0] recDiv4;
    reg  recSrcOsc;
    reg  recSwitching;
    reg  recNewDly;
    wire recNewLvl = recSrcOsc ? masterClkOut : oscLvl;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            recSrcOsc    <= 1'b0;
            recSwitching <= 1'b0;
            recBase      <= 1'b0;
            recNewDly    <= 1'b0;
        end else begin
            recNewDly <= recNewLvl;
            if (!recSwitching && recFromOsc != recSrcOsc && !recBase) begin
                recSwitching <= 1'b1;
            end else if (recSwitching) begin
                recBase <= 1'b0;
                if (!recNewLvl && recNewDly) begin
                    recSrcOsc    <= ~recSrcOsc;
                    recSwitching <= 1'b0;
                end
            end else begin
                recBase <= recSrcOsc ? oscLvl : masterClkOut;
            end
        end
    end
    wire recRise = recBase & ~recBaseDly;
    wire recEdge = recBase ^ recBaseDly;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            recBaseDly        <= 1'b0;
            recDiv2           <= 1'b0;
            recDiv4           <= 2'h0;
            recoveredClockOut <= 1'b0;
        end else begin
            recBaseDly <= recBase;
            if (recRise) begin
                recDiv2 <= ~recDiv2;
                recDiv4 <= recDiv4 + 2'h1;
            end
            case (recScale)
                `CMCC_SCALE_DIV1: recoveredClockOut <= recBase;
                `CMCC_SCALE_DIV2: recoveredClockOut <= recDiv2;
                `CMCC_SCALE_DIV4: recoveredClockOut <= recDiv4[1];
                // Doubling only resolves to the sampling clock: one-cycle pulse per edge
                `CMCC_SCALE_MUL2: recoveredClockOut <= recEdge;
                default:          recoveredClockOut <= recBase;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Serial port clocks
    // ------------------------------------------------------------------------
    reg  [7:0] mclkCnt;
    reg        mclkDly;
    reg  [1:0] bitOut;
    reg  [1:0] frameOut;
    reg  [1:0] portOe;
    wire [1:0] portMaster = {playIsMaster, capIsMaster};
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mclkCnt <= 8'h00;
            mclkDly <= 1'b0;
        end else begin
            mclkDly <= masterClkOut;
            if (masterClkOut && !mclkDly) begin
                mclkCnt <= mclkCnt + 8'h01;
            end
        end
    end

    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : gPort
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    bitOut[gi]   <= 1'b0;
                    frameOut[gi] <= 1'b0;
                    portOe[gi]   <= 1'b0;
                end else begin
                    portOe[gi]   <= portMaster[gi];
                    bitOut[gi]   <= portMaster[gi] & mclkCnt[`CMCC_BIT_TAP];
                    frameOut[gi] <= portMaster[gi] & mclkCnt[`CMCC_FRAME_TAP];
                end
            end
        end
    endgenerate
    assign capBitClkOut    = bitOut[0];
    assign capFrameClkOut  = frameOut[0];
    assign capBitClkOe     = portOe[0];
    assign capFrameClkOe   = portOe[0];
    assign playBitClkOut   = bitOut[1];
    assign playFrameClkOut = frameOut[1];
    assign playBitClkOe    = portOe[1];
    assign playFrameClkOe  = portOe[1];
    // ------------------------------------------------------------------------
    // PLL steering and status outputs
    // ------------------------------------------------------------------------
    wire lockToFrame = frameLockEn && !capIsMaster;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pllRefClkOut       <= 1'b0;
            pllFrameLockActive <= 1'b0;
            pllForcedLock      <= 1'b0;
            pllRangeSel        <= `CMCC_RANGE_12M;
            timingValid        <= 1'b0;
            sampleRateDetectEn <= 1'b0;
        end else begin
            // Slave capture frame clock supplied by the far side
            pllRefClkOut       <= lockToFrame & capFrame;
            pllFrameLockActive <= lockToFrame;
            pllForcedLock      <= forcedLock;
            pllRangeSel        <= refRange;
            timingValid        <= !(activeOsc == 1'b0 && unlock && !forcedLock);
            sampleRateDetectEn <= !forcedLock;
        end
    end

    // ------------------------------------------------------------------------
    // Ratio and frequency measurement
    // ------------------------------------------------------------------------
    wire [7:0]  ratioCount;
    wire [10:0] pllCount;
    // Oscillator edges over 64 PLL edges is the ratio times 64
    cmcc_edge_window #(.REF_COUNT(`CMCC_RATIO_WINDOW), .REF_WIDTH(6), .WIDTH(8)) uRatio (
        .clk(clk), .rst_n(rst_n), .refEdge(pllRise), .measEdge(oscRise), .count(ratioCount)
    );
    cmcc_edge_window #(.REF_COUNT(`CMCC_FREQ_WINDOW), .REF_WIDTH(8), .WIDTH(11)) uFreq (
        .clk(clk), .rst_n(rst_n), .refEdge(oscRise), .measEdge(pllRise), .count(pllCount)
    );
    // Nearest entry; exact only for the 12.288 MHz family of oscillators
    function [2:0] freqCode;
        input [10:0] cnt;
        input [1:0]  range;
        reg   [11:0] units;
        begin
            case (range)
                `CMCC_RANGE_18M: units = {1'b0, cnt} + {2'b00, cnt[10:1]};
                `CMCC_RANGE_24M: units = {cnt, 1'b0};
                default:         units = {1'b0, cnt};
            endcase
            if (units < `CMCC_THR_0)      freqCode = 3'h0;
            else if (units < `CMCC_THR_1) freqCode = 3'h1;
            else if (units < `CMCC_THR_2) freqCode = 3'h2;
            else if (units < `CMCC_THR_3) freqCode = 3'h3;
            else if (units < `CMCC_THR_4) freqCode = 3'h4;
            else if (units < `CMCC_THR_5) freqCode = 3'h5;
            else if (units < `CMCC_THR_6) freqCode = 3'h6;
            else                          freqCode = 3'h7;
        end
    endfunction
    wire [2:0] pllCode = forcedLock ? `CMCC_CODE_FORCED : freqCode(pllCount, refRange);
    // ------------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            case (regAddr)
                `CMCC_ADDR_PORT_ROLE:    regRdData <= {6'h00, portRole};
                `CMCC_ADDR_CLOCK_SOURCE: regRdData <= clockSource;
                `CMCC_ADDR_RATIO:        regRdData <= forcedLock ? 8'h00 : ratioCount;
                `CMCC_ADDR_CLOCK_STATE:  regRdData <= {4'h0, activeOsc, pllCode};
                default:                 regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end
endmodule // cmcc_clock_control
`default_nettype wire

// *** verification/cmcc_far_side.sv ***
// Far side model: oscillator, PLL output and slave-port clocks
`timescale 1ns/1ns
`default_nettype none
module cmcc_far_side #(
    parameter OSC_HALF = 100,
    parameter PLL_HALF = 80
) (
    output logic oscClk   = 1'b0,
    output logic pllClk   = 1'b0,
    output logic bitClk   = 1'b0,
    output logic frameClk = 1'b0
);
    // -------------------------------------------------------------
    // Slow sources, since the block samples every pin at 50 MHz
    // -------------------------------------------------------------
    always #(OSC_HALF) oscClk = ~oscClk;
    always #(PLL_HALF) pllClk = ~pllClk;
    always #160 bitClk = ~bitClk;
    // Frame clock runs free so slave ports never lose it
    always #5120 frameClk = ~frameClk;
endmodule // cmcc_far_side
`default_nettype wire

// *** verification/cmcc_assertions.sv ***
// Port-level checker for the clock control block
`timescale 1ns/1ns
`default_nettype none
module cmcc_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] regAddr,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic       capBitClkOut,
    input wire logic       capBitClkOe,
    input wire logic       playFrameClkOut,
    input wire logic       playFrameClkOe,
    input wire logic       capFrameClkOe,
    input wire logic       masterClkOut,
    input wire logic       pllFrameLockActive,
    input wire logic       pllForcedLock,
    input wire logic       timingValid,
    input wire logic       sampleRateDetectEn
);
    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_cap_slave_low: assert property (!capBitClkOe |-> !capBitClkOut)
        else $error("capture bit clock high in slave role");
    a_play_slave_low: assert property (!playFrameClkOe |-> !playFrameClkOut)
        else $error("playback frame clock high in slave role");
    a_lock_needs_slave: assert property (pllFrameLockActive |-> !capFrameClkOe)
        else $error("frame lock active with capture port master");
    a_forced_no_detect: assert property (pllForcedLock |-> !sampleRateDetectEn)
        else $error("rate detect left on under forced lock");
    a_forced_timing: assert property (pllForcedLock |-> timingValid)
        else $error("timing flagged invalid under forced lock");
    a_forced_code: assert property ($past(regRdEn) && $past(regAddr) == 8'h08
        && $past(pllForcedLock) && pllForcedLock |-> regRdData[2:0] == 3'h7)
        else $error("frequency code not 7 under forced lock");
    a_forced_ratio: assert property ($past(regRdEn) && $past(regAddr) == 8'h07
        && $past(pllForcedLock) && pllForcedLock |-> regRdData == 8'h00)
        else $error("ratio not cleared under forced lock");
    // Short pulses would mean a glitch while switching sources
    a_master_high_min: assert property ($rose(masterClkOut) |=> masterClkOut [*2])
        else $error("master clock high pulse too short");
    a_master_low_min: assert property ($fell(masterClkOut) |=> !masterClkOut [*2])
        else $error("master clock low pulse too short");
    c_forced: cover property (pllForcedLock && !sampleRateDetectEn);
    c_frame_lock: cover property (pllFrameLockActive);
    c_invalid: cover property (!timingValid);
    c_port_master: cover property (capBitClkOe && playFrameClkOe);
endmodule // cmcc_checker
bind cmcc_clock_control cmcc_checker u_chk (.clk, .rst_n, .regAddr, .regRdEn, .regRdData,
    .capBitClkOut, .capBitClkOe, .playFrameClkOut, .playFrameClkOe, .capFrameClkOe,
    .masterClkOut, .pllFrameLockActive, .pllForcedLock, .timingValid, .sampleRateDetectEn);
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the clock control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top;
    logic       clk, rst_n, regWrEn, regRdEn, pllUnlockIn, rdSeen, pM, pR, pB, pP;
    logic [7:0] regAddr, regWrData, r, expQ[$], mskQ[$];
    wire  [7:0] regRdData;
    wire  [1:0] pllRangeSel;
    wire        oscClkIn, pllClkIn, bitC, frm, playBitClkOut, playBitClkOe;
    wire        playFrameClkOut, playFrameClkOe, capBitClkOut, capBitClkOe;
    wire        capFrameClkOut, capFrameClkOe, masterClkOut, recoveredClockOut;
    wire        pllRefClkOut, pllFrameLockActive, pllForcedLock, timingValid;
    wire        sampleRateDetectEn;
    int         error_cnt, cmp_count, cyc, nM, nR, nB, nP, e;
    int         mulT[4] = '{4, 2, 1, 8};
    logic [1:0] selT[9] = '{0, 1, 0, 3, 3, 3, 2, 2, 2};
    logic       unlT[9] = '{0, 0, 1, 0, 1, 0, 0, 1, 0};
    logic       expT[9] = '{0, 1, 0, 0, 1, 0, 0, 1, 1};
    // Pin level: the block when it drives, else the far side
    wire playBitClkIn   = playBitClkOe ? playBitClkOut : bitC;
    wire playFrameClkIn = playFrameClkOe ? playFrameClkOut : frm;
    wire capBitClkIn    = capBitClkOe ? capBitClkOut : bitC;
    wire capFrameClkIn  = capFrameClkOe ? capFrameClkOut : frm;
    cmcc_far_side far (.oscClk(oscClkIn), .pllClk(pllClkIn), .bitClk(bitC), .frameClk(frm));
    cmcc_clock_control DUT (.clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn,
        .regRdData, .oscClkIn, .pllClkIn, .pllUnlockIn, .playBitClkIn, .playBitClkOut,
        .playBitClkOe, .playFrameClkIn, .playFrameClkOut, .playFrameClkOe, .capBitClkIn,
        .capBitClkOut, .capBitClkOe, .capFrameClkIn, .capFrameClkOut, .capFrameClkOe,
        .masterClkOut, .recoveredClockOut, .pllRefClkOut, .pllFrameLockActive,
        .pllForcedLock, .pllRangeSel, .timingValid, .sampleRateDetectEn);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // -------------------------------------------------------------
    // Edge counters, timeout and read-data scoreboard
    // -------------------------------------------------------------
    always @(posedge clk) begin
        rdSeen <= regRdEn;
        pM <= masterClkOut;
        pR <= recoveredClockOut;
        pB <= capBitClkOut;
        pP <= playBitClkOut;
        if (masterClkOut && !pM) nM++;
        if (recoveredClockOut && !pR) nR++;
        if (capBitClkOut && !pB) nB++;
        if (playBitClkOut && !pP) nP++;
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    // Read data stands only in the cycle after the strobe
    always @(negedge clk) if (rdSeen) begin
        `CHK("read data", expQ[0] & mskQ[0], regRdData & mskQ[0])
        void'(expQ.pop_front());
        void'(mskQ.pop_front());
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] m);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        expQ.push_back(ex);
        mskQ.push_back(m);
        @(posedge clk);
        regRdEn <= 1'b0;
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        {rst_n, regWrEn, regRdEn, pllUnlockIn} = 4'h0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        void'($urandom(61975));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h05, 8'h00, 8'hFF);
        rd(8'h06, 8'h00, 8'hFF);
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h03, 8'hFF);
        repeat (5) @(posedge clk);
        `CHK("capture bit oe", 1'b1, capBitClkOe)
        `CHK("playback frame oe", 1'b1, playFrameClkOe)
        for (int s = 0; s < 4; s++) begin
            wr(8'h06, 8'(s << 6));
            repeat (40) @(posedge clk);
            {nM, nR, nB, nP} = 0;
            repeat (1600) @(posedge clk);
            e = nM * mulT[s] / 4;
            `CHK("recovered rises near", 1'b1, (nR - e) inside {[-2:2]})
        end
        `CHK("bit clock rises near", 1'b1, (nB - nM / 4) inside {[-2:2]})
        `CHK("playback bit rises near", 1'b1, (nP - nM / 4) inside {[-2:2]})
        wr(8'h05, 8'h00);
        wr(8'h06, 8'h00);
        repeat (5) @(posedge clk);
        `CHK("capture bit oe", 1'b0, capBitClkOe)
        // Ratio 0.8 (oscillator over PLL) with loose low bits, since windows float
        rd(8'h07, 8'h33, 8'hF8);
        rd(8'h08, 8'h03, 8'hFF);
        r = 8'($urandom);
        wr(8'h07, r);
        rd(8'h07, 8'h33, 8'hF8);
        rd(8'h09 + r[5:0], 8'h00, 8'hFF);
        wr(8'h06, {2'b00, r[1:0], 4'h0});
        repeat (3) @(posedge clk);
        `CHK("range copy", r[1:0], pllRangeSel)
        rd(8'h06, {2'b00, r[1:0], 4'h0}, 8'hFF);
        wr(8'h06, 8'h08);
        repeat (3) @(posedge clk);
        `CHK("frame lock", 1'b1, pllFrameLockActive)
        @(posedge frm);
        repeat (8) @(posedge clk);
        `CHK("frame to PLL", 1'b1, pllRefClkOut)
        @(negedge frm);
        repeat (8) @(posedge clk);
        `CHK("frame to PLL", 1'b0, pllRefClkOut)
        wr(8'h05, 8'h01);
        repeat (3) @(posedge clk);
        `CHK("frame lock", 1'b0, pllFrameLockActive)
        wr(8'h05, 8'h00);
        for (int i = 0; i < 9; i++) begin
            pllUnlockIn <= unlT[i];
            wr(8'h06, {5'h00, selT[i], 1'b0});
            repeat (60) @(posedge clk);
            rd(8'h08, {4'h0, expT[i], 3'h0}, 8'h08);
            `CHK("timing valid", !(expT[i] == 1'b0 && unlT[i]), timingValid)
        end
        pllUnlockIn <= 1'b1;
        wr(8'h06, 8'h01);
        repeat (40) @(posedge clk);
        rd(8'h07, 8'h00, 8'hFF);
        rd(8'h08, 8'h07, 8'hFF);
        `CHK("detect enable", 1'b0, sampleRateDetectEn)
        `CHK("timing valid", 1'b1, timingValid)
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
